/* File: hdl/tfa_pkg.sv */
// Behaviour
// - quick-start bit set: high oscillator current from power-down to transmit; else constant bias.
// - supply detect enabled raises low-supply flag below threshold picked by level and bypass.
// - without lock gating, amplifier on only in transmit mode with output level above zero.
// - with lock gating in transmit mode, amplifier turns on when lock indication is 1.
// - lock gating: load pulse or open-loop floating data input turns amplifier off; lock re-enables.
// - byte mode without start gating: modulation starts once frame length is written.
// - start gating: modulation waits for length written, amplifier on and lock high.
// - frame-end control on: amplifier off right after the last frame bit.
// - frame-end control off: without lock gating, amplifier off only by mode or output level.
// - lock output enabled: lock pin high while the PLL is locked.
// - lock output disabled: lock pin low or the selected internal test signal.
// - sync word is length field plus one bytes, sync byte zero sent first.
// - preamble is preamble field plus one bytes long.
// - CRC select 10 appends one CRC-8 byte, x^8+x^5+x^4+1; upper bit 0 appends none.
// - CRC select 11 appends two CRC-16 bytes, x^16+x^12+x^5+1.
// - frame length counts the CRC bytes; host includes them, device ends frame by it.
// - byte mode with Manchester bit set encodes frame data; clear sends plain data.
// - serial enable rising edge loads configuration; sync and data bytes act at once.
// - bit mode without synchroniser passes data input straight through, data clock idle.
package tfa_pkg;
   localparam logic [4:0] IX_MISC = 5'h0b;
   localparam logic [4:0] IX_AMP = 5'h0c;
   localparam logic [4:0] IX_FRM = 5'h0d;
   localparam logic [4:0] IX_RATE = 5'h0f;
   localparam logic [4:0] IX_OSC = 5'h15;
   localparam logic [4:0] IX_TEST = 5'h16;
   localparam logic [4:0] IX_STAT = 5'h18;
   localparam logic [4:0] IX_SYNC3 = 5'h19;
   localparam logic [4:0] IX_SYNC2 = 5'h1a;
   localparam logic [4:0] IX_SYNC1 = 5'h1b;
   localparam logic [4:0] IX_SYNC0 = 5'h1c;
   localparam logic [4:0] IX_DATA = 5'h1d;
   localparam logic [4:0] IX_MODE = 5'h1e;
   localparam logic [4:0] IX_BITPER = 5'h1f;
   localparam logic [7:0] RST_MISC = 8'hae;
   localparam logic [7:0] RST_AMP = 8'h31;
   localparam logic [7:0] RST_FRM = 8'hb6;
   localparam logic [7:0] RST_RATE = 8'h24;
   localparam logic [7:0] RST_OSC = 8'h30;
   localparam logic [7:0] RST_TEST = 8'h00;
   localparam logic [7:0] RST_SYNC = 8'he5;
   localparam logic [7:0] RST_MODE = 8'h1c;
   localparam logic [15:0] RST_BITPER = 16'h0064;
   localparam int MS_DET_EN = 7;
   localparam int MS_MOD = 0;
   localparam int AM_LEVEL = 7;
   localparam int AM_BYPASS = 6;
   localparam int AM_MOD_GATE = 3;
   localparam int AM_FE_OFF = 2;
   localparam int AM_LOCK_GATE = 1;
   localparam int AM_LOCK_OUT = 0;
   localparam int FR_BITIO = 7;
   localparam int FR_MANCH = 6;
   localparam int FR_CRC_HI = 5;
   localparam int FR_CRC_LO = 4;
   localparam int FR_SYNC = 2;
   localparam int FR_PRE = 0;
   localparam int OS_QUICK = 5;
   localparam int MD_MODE = 0;
   localparam int MD_LEVEL = 2;
   localparam int MD_SYNC_EN = 5;
   localparam int ST_LOW = 0;
   localparam int ST_PA = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_HOLD = 3;
   localparam int ST_LOCK = 4;
   localparam logic [1:0] MODE_PD = 2'h0;
   localparam logic [1:0] MODE_TX = 2'h3;
   localparam logic [1:0] MOD_OPEN = 2'h1;
   localparam logic [2:0] TS_GND = 3'h0;
   localparam logic [2:0] TS_SYMBOL = 3'h7;
   localparam logic [7:0] PREAMBLE = 8'haa;
   localparam logic [15:0] POLY8 = 16'h0031;
   localparam logic [15:0] POLY16 = 16'h1021;
   localparam int CLK_NS = 20;
   localparam int OSC_START_NS = 100000;
   localparam int OSC_START_CYC = OSC_START_NS / CLK_NS;
   typedef enum logic [2:0] {
      FR_IDLE = 3'h0,
      FR_ARM = 3'h1,
      FR_PREAM = 3'h3,
      FR_SYNCW = 3'h2,
      FR_PAY = 3'h6,
      FR_DONE = 3'h4
   } tfa_frame_t;
endpackage

/* File: hdl/tfa_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module tfa_sync2 #(
   parameter int W = 1
) (
   input wire logic i_clk_sys, // system clock
   input wire logic i_sys_rst, // sync reset
   input wire logic [W-1:0] i_async, // pin level
   output logic [W-1:0] o_sync // synchronised level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } tfa_sync_t;
   tfa_sync_t st, next_st;

   always_comb begin
      next_st.s1 = i_async;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_sync = st.s2;
endmodule
`default_nettype wire

/* File: hdl/tfa_crc_ser.sv */
`timescale 1ns/1ps
`default_nettype none
module tfa_crc_ser (
   input wire logic i_clk_sys, // system clock
   input wire logic i_sys_rst, // sync reset
   input wire logic i_clear, // back to all zero
   input wire logic i_en, // fold in one bit
   input wire logic i_bit, // bit on air
   input wire logic i_wide, // 1: 16-bit, 0: 8-bit
   output logic [15:0] o_crc_next // value after this cycle
);
   typedef struct packed {
      logic [15:0] crc;
   } tfa_crc_t;
   tfa_crc_t st, next_st;
   logic fb;

   always_comb begin
      next_st = st;
      fb = i_bit ^ (i_wide ? st.crc[15] : st.crc[7]);
      if (i_clear) begin
         next_st.crc = '0;
      end else if (i_en) begin
         if (i_wide) begin
            next_st.crc = {st.crc[14:0], 1'b0} ^ (fb ? tfa_pkg::POLY16 : 16'h0000);
         end else begin
            next_st.crc = {8'h00, st.crc[6:0], 1'b0} ^ (fb ? tfa_pkg::POLY8 : 16'h0000);
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_crc_next = next_st.crc;
endmodule
`default_nettype wire

/* File: hdl/tfa_frame_amp_ctl.sv */
`timescale 1ns/1ps
`default_nettype none
module tfa_frame_amp_ctl #(
   parameter int unsigned p_osc_start_cycles = tfa_pkg::OSC_START_CYC
) (
   input wire logic i_clk_sys, // 50 MHz clock
   input wire logic i_sys_rst, // sync reset, high
   input wire logic i_wb_cyc, // wishbone cycle
   input wire logic i_wb_stb, // wishbone strobe
   input wire logic i_wb_we, // wishbone write
   input wire logic [6:0] i_wb_adr, // byte address
   input wire logic [3:0] i_wb_sel, // byte lanes
   input wire logic [31:0] i_wb_dat, // write data
   output logic o_wb_ack, // wishbone ack
   output logic [31:0] o_wb_dat, // read data
   input wire logic i_serial_enable_line, // load pulse on rise
   input wire logic i_pll_lock_indication, // pll locked
   input wire logic i_serial_data_input, // bit-mode data pin
   input wire logic i_data_input_float, // data pin tri-stated
   input wire logic i_supply_below, // supply under threshold
   input wire logic [7:0] i_test_bus, // internal test signals
   output logic o_pa_enable, // power amplifier on
   output logic o_tx_symbol, // chip to modulator
   output logic o_data_clock, // ready or bit clock
   output logic o_lock_pin, // lock / test output
   output logic o_osc_high_current, // oscillator boost
   output logic o_supply_detect_enable, // detector on
   output logic [1:0] o_supply_threshold_sel, // {level, bypass}
   output logic o_low_supply_flag // sticky low supply
);
   typedef struct packed {
      logic ack;
      logic [31:0] rdata;
      logic [7:0] misc;
      logic [7:0] amp;
      logic [7:0] frm;
      logic [7:0] rate;
      logic [7:0] osc;
      logic [7:0] test;
      logic [7:0] mode;
      logic [15:0] bitper;
      logic [7:0] a_misc;
      logic [7:0] a_amp;
      logic [7:0] a_frm;
      logic [7:0] a_osc;
      logic [7:0] a_test;
      logic [7:0] a_mode;
      logic [15:0] a_bitper;
      logic [3:0][7:0] syncw;
      logic [7:0] hold;
      logic hold_full;
      logic low;
      logic sen_q;
      logic lock_q;
      logic [1:0] mode_q;
      tfa_pkg::tfa_frame_t fr;
      logic [7:0] remaining;
      logic [7:0] sh;
      logic [2:0] bitcnt;
      logic half;
      logic stall;
      logic crc_phase;
      logic [1:0] idx;
      logic [15:0] tick_cnt;
      logic mod_out;
      logic dclk;
      logic pa_lc;
      logic fe_off;
      logic pa_on;
      logic osc_hi;
      logic [15:0] osc_cnt;
      logic lock_pin;
   } tfa_state_t;
   tfa_state_t st, next_st;

   ////////////////////////////////////////////////////////////////////////
   logic [4:0] pin_s;
   logic [7:0] test_s;
   logic [15:0] crc_next;
   logic crc_clr;
   logic crc_en;
   logic sen_s, lock_s, data_s, float_s, below_s;

   tfa_sync2 #(.W(5)) u_pin_sync (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_async({i_supply_below, i_data_input_float, i_serial_data_input,
                i_pll_lock_indication, i_serial_enable_line}),
      .o_sync(pin_s)
   );

   tfa_sync2 #(.W(8)) u_test_sync (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_async(i_test_bus),
      .o_sync(test_s)
   );

   assign {below_s, float_s, data_s, lock_s, sen_s} = pin_s;

   tfa_crc_ser u_crc (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_clear(crc_clr),
      .i_en(crc_en),
      .i_bit(st.sh[7]),
      .i_wide(st.a_frm[tfa_pkg::FR_CRC_LO]),
      .o_crc_next(crc_next)
   );

   ////////////////////////////////////////////////////////////////////////
   logic req, wr, load, tick, bitio, manch, tx, gate_ok, byte_end, pay_next;
   logic [4:0] aix;
   logic [15:0] reload;
   logic [7:0] crc_n;

   always_comb begin
      next_st = st;
      crc_clr = 1'b0;
      crc_en = 1'b0;
      byte_end = 1'b0;
      pay_next = 1'b0;
      req = i_wb_cyc & i_wb_stb & ~st.ack;
      wr = req & i_wb_we & i_wb_sel[0];
      aix = i_wb_adr[6:2];
      // sync bytes, data and the low-flag clear act at once; misc, amp, frm, osc, test, mode and bitper wait for a load pulse
      load = sen_s & ~st.sen_q;
      bitio = st.a_frm[tfa_pkg::FR_BITIO];
      manch = st.a_frm[tfa_pkg::FR_MANCH];
      tx = (st.a_mode[tfa_pkg::MD_MODE +: 2] == tfa_pkg::MODE_TX);
      crc_n = st.a_frm[tfa_pkg::FR_CRC_HI] ? (st.a_frm[tfa_pkg::FR_CRC_LO] ? 8'h02 : 8'h01) : 8'h00;
      reload = (st.a_bitper[15:1] == 15'h0000) ? 16'h0000 : {1'b0, st.a_bitper[15:1]} - 16'h0001;
      tick = (st.tick_cnt == 16'h0000);
      gate_ok = ~st.a_amp[tfa_pkg::AM_MOD_GATE] | (st.pa_on & lock_s);
      next_st.sen_q = sen_s;
      next_st.lock_q = lock_s;
      next_st.mode_q = st.a_mode[tfa_pkg::MD_MODE +: 2];
      next_st.tick_cnt = tick ? reload : st.tick_cnt - 16'h0001;

      // bus answer: one wait cycle, unmapped reads zero
      next_st.ack = req;
      next_st.rdata = '0;
      if (req && !i_wb_we) begin
         unique case (aix)
            tfa_pkg::IX_MISC: next_st.rdata[7:0] = st.misc;
            tfa_pkg::IX_AMP: next_st.rdata[7:0] = st.amp;
            tfa_pkg::IX_FRM: next_st.rdata[7:0] = st.frm;
            tfa_pkg::IX_RATE: next_st.rdata[7:0] = st.rate;
            tfa_pkg::IX_OSC: next_st.rdata[7:0] = st.osc;
            tfa_pkg::IX_TEST: next_st.rdata[7:0] = st.test;
            tfa_pkg::IX_STAT: begin
               next_st.rdata[tfa_pkg::ST_LOW] = st.low;
               next_st.rdata[tfa_pkg::ST_PA] = st.pa_on;
               next_st.rdata[tfa_pkg::ST_BUSY] = (st.fr != tfa_pkg::FR_IDLE);
               next_st.rdata[tfa_pkg::ST_HOLD] = st.hold_full;
               next_st.rdata[tfa_pkg::ST_LOCK] = lock_s;
            end
            tfa_pkg::IX_SYNC3: next_st.rdata[7:0] = st.syncw[3];
            tfa_pkg::IX_SYNC2: next_st.rdata[7:0] = st.syncw[2];
            tfa_pkg::IX_SYNC1: next_st.rdata[7:0] = st.syncw[1];
            tfa_pkg::IX_SYNC0: next_st.rdata[7:0] = st.syncw[0];
            tfa_pkg::IX_DATA: next_st.rdata[7:0] = st.remaining;
            tfa_pkg::IX_MODE: next_st.rdata[7:0] = st.mode;
            tfa_pkg::IX_BITPER: next_st.rdata[15:0] = st.bitper;
            default: next_st.rdata = '0;
         endcase
      end

      if (load) begin
         next_st.a_misc = st.misc;
         next_st.a_amp = st.amp;
         next_st.a_frm = st.frm;
         next_st.a_osc = st.osc;
         next_st.a_test = st.test;
         next_st.a_mode = st.mode;
         next_st.a_bitper = st.bitper;
      end

      ////////////////////////////////////////////////////////////////////
      // frame engine; each bit is two half-bit ticks so Manchester costs nothing extra
      unique case (st.fr)
         tfa_pkg::FR_IDLE: begin
         end
         tfa_pkg::FR_ARM: begin
            if (gate_ok) begin
               next_st.fr = tfa_pkg::FR_PREAM;
               next_st.sh = tfa_pkg::PREAMBLE;
               next_st.idx = 2'h0;
               next_st.bitcnt = 3'h0;
               next_st.half = 1'b0;
               next_st.tick_cnt = reload;
               crc_clr = 1'b1;
            end
         end
         tfa_pkg::FR_PREAM, tfa_pkg::FR_SYNCW, tfa_pkg::FR_PAY: begin
            if (st.stall) begin
               pay_next = st.hold_full;
            end else if (tick) begin
               if (!st.half) begin
                  next_st.mod_out = st.sh[7];
                  next_st.half = 1'b1;
               end else begin
                  next_st.mod_out = manch ? ~st.sh[7] : st.sh[7];
                  next_st.half = 1'b0;
                  crc_en = (st.fr == tfa_pkg::FR_PAY) & ~st.crc_phase;
                  if (st.bitcnt != 3'h7) begin
                     next_st.sh = {st.sh[6:0], 1'b0};
                     next_st.bitcnt = st.bitcnt + 3'h1;
                  end else begin
                     next_st.bitcnt = 3'h0;
                     byte_end = 1'b1;
                  end
               end
            end
         end
         tfa_pkg::FR_DONE: begin
            next_st.fr = tfa_pkg::FR_IDLE;
            next_st.mod_out = 1'b0;
            if (st.a_amp[tfa_pkg::AM_FE_OFF]) begin
               next_st.fe_off = 1'b1;
            end
         end
         default: next_st.fr = tfa_pkg::FR_IDLE;
      endcase

      if (byte_end) begin
         unique case (st.fr)
            tfa_pkg::FR_PREAM: begin
               if (st.idx == st.a_frm[tfa_pkg::FR_PRE +: 2]) begin
                  next_st.fr = tfa_pkg::FR_SYNCW;
                  next_st.idx = 2'h0;
                  next_st.sh = st.syncw[0];
               end else begin
                  next_st.idx = st.idx + 2'h1;
                  next_st.sh = tfa_pkg::PREAMBLE;
               end
            end
            tfa_pkg::FR_SYNCW: begin
               if (st.idx == st.a_frm[tfa_pkg::FR_SYNC +: 2]) begin
                  pay_next = 1'b1;
               end else begin
                  next_st.idx = st.idx + 2'h1;
                  next_st.sh = st.syncw[st.idx + 2'h1];
               end
            end
            default: pay_next = 1'b1;
         endcase
      end

      // length includes the CRC bytes, so the tail of the count is the checksum
      if (pay_next) begin
         next_st.fr = tfa_pkg::FR_PAY;
         next_st.stall = 1'b0;
         if (st.remaining == 8'h00) begin
            next_st.fr = tfa_pkg::FR_DONE;
         end else if (st.remaining <= crc_n) begin
            next_st.sh = (st.remaining == 8'h02) ? crc_next[15:8] : crc_next[7:0];
            next_st.remaining = st.remaining - 8'h01;
            next_st.crc_phase = 1'b1;
         end else if (st.hold_full) begin
            next_st.sh = st.hold;
            next_st.hold_full = 1'b0;
            next_st.remaining = st.remaining - 8'h01;
         end else begin
            // underrun: the line holds its last level until the host refills
            next_st.stall = 1'b1;
         end
      end

      ////////////////////////////////////////////////////////////////////
      if (wr) begin
         unique case (aix)
            tfa_pkg::IX_MISC: next_st.misc = i_wb_dat[7:0];
            tfa_pkg::IX_AMP: next_st.amp = i_wb_dat[7:0];
            tfa_pkg::IX_FRM: next_st.frm = i_wb_dat[7:0];
            tfa_pkg::IX_RATE: next_st.rate = i_wb_dat[7:0];
            tfa_pkg::IX_OSC: next_st.osc = i_wb_dat[7:0];
            tfa_pkg::IX_TEST: next_st.test = i_wb_dat[7:0];
            tfa_pkg::IX_STAT: begin
               // hardware set wins over a clear in the same cycle
               if (i_wb_dat[tfa_pkg::ST_LOW]) begin
                  next_st.low = 1'b0;
               end
            end
            tfa_pkg::IX_SYNC3: next_st.syncw[3] = i_wb_dat[7:0];
            tfa_pkg::IX_SYNC2: next_st.syncw[2] = i_wb_dat[7:0];
            tfa_pkg::IX_SYNC1: next_st.syncw[1] = i_wb_dat[7:0];
            tfa_pkg::IX_SYNC0: next_st.syncw[0] = i_wb_dat[7:0];
            tfa_pkg::IX_DATA: begin
               if (st.fr == tfa_pkg::FR_IDLE && !bitio) begin
                  next_st.remaining = i_wb_dat[7:0];
                  next_st.fr = tfa_pkg::FR_ARM;
                  next_st.fe_off = 1'b0;
                  next_st.crc_phase = 1'b0;
               end else if (!st.hold_full) begin
                  next_st.hold = i_wb_dat[7:0];
                  next_st.hold_full = 1'b1;
               end
            end
            tfa_pkg::IX_MODE: next_st.mode = i_wb_dat[7:0];
            tfa_pkg::IX_BITPER: next_st.bitper = i_wb_dat[15:0];
            default: begin
            end
         endcase
      end

      if (st.a_misc[tfa_pkg::MS_DET_EN] && below_s) begin
         next_st.low = 1'b1;
      end

      ////////////////////////////////////////////////////////////////////
      // bit mode bypasses the framer entirely
      if (bitio) begin
         next_st.fr = tfa_pkg::FR_IDLE;
         next_st.stall = 1'b0;
         if (!st.a_mode[tfa_pkg::MD_SYNC_EN]) begin
            next_st.mod_out = data_s;
            next_st.dclk = 1'b0;
         end else if (tick) begin
            next_st.dclk = ~st.dclk;
            if (!st.dclk) begin
               next_st.mod_out = data_s;
            end
         end
      end else begin
         next_st.dclk = ~st.hold_full;
      end

      // amplifier control
      if (!(st.a_amp[tfa_pkg::AM_LOCK_GATE] && tx)) begin
         next_st.pa_lc = 1'b0;
      end else if ((lock_s && !st.lock_q) || (lock_s && st.mode_q != tfa_pkg::MODE_TX)) begin
         next_st.pa_lc = 1'b1;
      end else if (load || (st.a_misc[tfa_pkg::MS_MOD +: 2] == tfa_pkg::MOD_OPEN && float_s)) begin
         next_st.pa_lc = 1'b0;
      end
      if (!tx) begin
         next_st.fe_off = 1'b0;
      end
      if (st.a_amp[tfa_pkg::AM_LOCK_GATE]) begin
         next_st.pa_on = st.pa_lc & ~st.fe_off;
      end else begin
         next_st.pa_on = tx & (st.a_mode[tfa_pkg::MD_LEVEL +: 3] != 3'h0) & ~st.fe_off;
      end

      // oscillator boost only on a direct power-down to transmit step
      if (!tx) begin
         next_st.osc_hi = 1'b0;
      end else if (st.mode_q == tfa_pkg::MODE_PD && st.a_osc[tfa_pkg::OS_QUICK]) begin
         next_st.osc_hi = 1'b1;
         next_st.osc_cnt = p_osc_start_cycles[15:0];
      end else if (st.osc_cnt != 16'h0000) begin
         next_st.osc_cnt = st.osc_cnt - 16'h0001;
      end else begin
         next_st.osc_hi = 1'b0;
      end

      // lock pin
      if (st.a_amp[tfa_pkg::AM_LOCK_OUT]) begin
         next_st.lock_pin = lock_s;
      end else if (st.a_test[2:0] == tfa_pkg::TS_GND) begin
         next_st.lock_pin = 1'b0;
      end else if (st.a_test[2:0] == tfa_pkg::TS_SYMBOL) begin
         next_st.lock_pin = st.mod_out;
      end else begin
         next_st.lock_pin = test_s[st.a_test[2:0]];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st <= '0;
         st.misc <= tfa_pkg::RST_MISC;
         st.amp <= tfa_pkg::RST_AMP;
         st.frm <= tfa_pkg::RST_FRM;
         st.rate <= tfa_pkg::RST_RATE;
         st.osc <= tfa_pkg::RST_OSC;
         st.test <= tfa_pkg::RST_TEST;
         st.mode <= tfa_pkg::RST_MODE;
         st.bitper <= tfa_pkg::RST_BITPER;
         st.a_misc <= tfa_pkg::RST_MISC;
         st.a_amp <= tfa_pkg::RST_AMP;
         st.a_frm <= tfa_pkg::RST_FRM;
         st.a_osc <= tfa_pkg::RST_OSC;
         st.a_test <= tfa_pkg::RST_TEST;
         st.a_mode <= tfa_pkg::RST_MODE;
         st.a_bitper <= tfa_pkg::RST_BITPER;
         st.syncw <= {4{tfa_pkg::RST_SYNC}};
         st.fr <= tfa_pkg::FR_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign o_wb_ack = st.ack;
   assign o_wb_dat = st.rdata;
   assign o_pa_enable = st.pa_on;
   assign o_tx_symbol = st.mod_out;
   assign o_data_clock = st.dclk;
   assign o_lock_pin = st.lock_pin;
   assign o_osc_high_current = st.osc_hi;
   assign o_supply_detect_enable = st.a_misc[tfa_pkg::MS_DET_EN];
   assign o_supply_threshold_sel = {st.a_amp[tfa_pkg::AM_LEVEL], st.a_amp[tfa_pkg::AM_BYPASS]};
   assign o_low_supply_flag = st.low;
endmodule
`default_nettype wire

/* File: bench/tfa_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module tfa_checker #(
   parameter int unsigned p_osc_start_cycles = 5000
) (
   input wire logic i_clk_sys, // clock
   input wire logic i_sys_rst, // reset
   input wire logic i_wb_cyc, // cycle
   input wire logic i_wb_stb, // strobe
   input wire logic i_serial_enable_line, // load line
   input wire logic o_wb_ack, // ack
   input wire logic [31:0] o_wb_dat, // read data
   input wire logic o_osc_high_current, // boost
   input wire logic o_supply_detect_enable, // detector
   input wire logic [1:0] o_supply_threshold_sel, // threshold
   input wire logic o_low_supply_flag // flag
);
   logic [15:0] ocnt;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   // counts sampled boost cycles so the span is checked without a long repetition
   always_ff @(posedge i_clk_sys) ocnt <= (i_sys_rst || !o_osc_high_current) ? 16'h0000 : ocnt + 16'h0001;
   bus_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
   ack_single_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack held");
   rdat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("rdat idle");
   osc_span_a: assert property ($fell(o_osc_high_current) |-> ocnt == 16'(p_osc_start_cycles + 1))
      else $error("osc span");
   thr_load_a: assert property ($changed(o_supply_threshold_sel) |-> $past(i_serial_enable_line))
      else $error("thr no load");
   det_load_a: assert property ($changed(o_supply_detect_enable) |-> $past(i_serial_enable_line))
      else $error("det no load");
   flag_hold_a: assert property (o_low_supply_flag && !i_wb_stb && !$past(i_wb_stb) |=> o_low_supply_flag)
      else $error("flag lost");
   flag_off_a: assert property (!o_supply_detect_enable ##1 !o_supply_detect_enable && !o_low_supply_flag
      |=> !o_low_supply_flag) else $error("flag off");
endmodule
bind tfa_frame_amp_ctl tfa_checker #(.p_osc_start_cycles(p_osc_start_cycles)) chk (.*);
`default_nettype wire

/* File: bench/tfa_host.sv */
`timescale 1ns/1ps
`default_nettype none
module tfa_host (
   input wire logic i_clk_sys, // clock
   input wire logic i_ack, // ack
   input wire logic [31:0] i_rdat, // read data
   output logic o_cyc, // cycle
   output logic o_stb, // strobe
   output logic o_we, // write
   output logic [6:0] o_adr, // address
   output logic [3:0] o_sel, // lanes
   output logic [31:0] o_dat, // write data
   output logic o_sen // load line
);
   // lock gating and manchester stay off, so no paired settings are owed
   initial {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat, o_sen} = '0;
   task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge i_clk_sys);
      {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'b11, w, a, 4'hf, 24'h0, d};
      do @(posedge i_clk_sys); while (i_ack !== 1'b1);
      q = i_rdat[7:0];
      {o_cyc, o_stb, o_we} <= 3'b000;
      o_dat <= ~o_dat;
   endtask
   task automatic load();
      @(posedge i_clk_sys);
      o_sen <= 1'b1;
      repeat (5) @(posedge i_clk_sys);
      o_sen <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: bench/test_tx_frame_and_amp_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_tx_frame_and_amp_control;
   logic i_clk_sys = 1'b0, i_sys_rst = 1'b1, i_pll_lock_indication = 1'b0, i_supply_below = 1'b0;
   logic i_serial_data_input = 1'b0, i_data_input_float = 1'b0;
   logic [7:0] i_test_bus = 8'h00, q;
   logic i_wb_cyc, i_wb_stb, i_wb_we, i_serial_enable_line, o_wb_ack, o_pa_enable, o_tx_symbol;
   logic o_data_clock, o_lock_pin, o_osc_high_current, o_supply_detect_enable, o_low_supply_flag;
   logic [6:0] i_wb_adr;
   logic [3:0] i_wb_sel;
   logic [31:0] i_wb_dat, o_wb_dat;
   logic [1:0] o_supply_threshold_sel;
   logic [31:0] air;
   int num_errors = 0, compares = 0;
   always #10 i_clk_sys = ~i_clk_sys;
   tfa_host host (.i_clk_sys(i_clk_sys), .i_ack(o_wb_ack), .i_rdat(o_wb_dat), .o_cyc(i_wb_cyc), .o_stb(i_wb_stb),
      .o_we(i_wb_we), .o_adr(i_wb_adr), .o_sel(i_wb_sel), .o_dat(i_wb_dat), .o_sen(i_serial_enable_line));
   tfa_frame_amp_ctl #(.p_osc_start_cycles(20)) uut (.*);
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.xfer(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      host.xfer(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask
   task automatic t_lock;
      rdc(7'h30, 8'h31);
      rdc(7'h00, 8'h00);
      i_pll_lock_indication <= 1'b1;
      i_serial_data_input <= 1'b1;
      i_test_bus <= 8'hff;
      repeat (4) @(posedge i_clk_sys);
      chk({7'h0, o_lock_pin}, 8'h01);
      chk({7'h0, o_tx_symbol}, 8'h01);
      chk({7'h0, o_data_clock}, 8'h00);
      i_serial_data_input <= 1'b0;
      wr(7'h30, 8'hc0);
      chk({6'h0, o_supply_threshold_sel}, 8'h00);
      host.load();
      chk({6'h0, o_supply_threshold_sel}, 8'h03);
      chk({7'h0, o_lock_pin}, 8'h00);
      wr(7'h58, 8'h03);
      host.load();
      chk({7'h0, o_lock_pin}, 8'h01);
   endtask
   task automatic t_flag;
      i_supply_below <= 1'b1;
      repeat (5) @(posedge i_clk_sys);
      chk({7'h0, o_low_supply_flag}, 8'h01);
      i_supply_below <= 1'b0;
      repeat (4) @(posedge i_clk_sys);
      wr(7'h60, 8'h01);
      repeat (2) @(posedge i_clk_sys);
      chk({7'h0, o_low_supply_flag}, 8'h00);
      // detector switched off: a low supply must not raise the flag
      wr(7'h2c, 8'h2e);
      host.load();
      i_supply_below <= 1'b1;
      repeat (5) @(posedge i_clk_sys);
      chk({7'h0, o_low_supply_flag}, 8'h00);
      i_supply_below <= 1'b0;
   endtask
   task automatic t_amp;
      wr(7'h78, 8'h1f);
      host.load();
      repeat (30) @(posedge i_clk_sys);
      chk({7'h0, o_pa_enable}, 8'h01);
      wr(7'h78, 8'h03);
      host.load();
      repeat (2) @(posedge i_clk_sys);
      chk({7'h0, o_pa_enable}, 8'h00);
   endtask
   task automatic t_frame;
      wr(7'h34, 8'h20);
      wr(7'h30, 8'hc4);
      wr(7'h78, 8'h1f);
      host.load();
      wr(7'h74, 8'h02);
      wr(7'h74, 8'h3c);
      for (int i = 0; i < 300 && o_tx_symbol !== 1'b1; i++) @(posedge i_clk_sys);
      repeat (50) @(posedge i_clk_sys);
      for (int i = 0; i < 32; i++) begin
         air = {air[30:0], o_tx_symbol};
         repeat (100) @(posedge i_clk_sys);
      end
      chk(air[31:24], tfa_pkg::PREAMBLE);
      chk(air[23:16], 8'he5);
      chk(air[15:8], 8'h3c);
      // crc-8 of the single payload byte 0x3c, worked by hand from the polynomial
      chk(air[7:0], 8'hb8);
      chk({7'h0, o_pa_enable}, 8'h00);
      chk({7'h0, o_data_clock}, 8'h01);
   endtask
   task automatic print_verdict;
      if (num_errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      t_lock();
      t_flag();
      t_amp();
      t_frame();
      print_verdict();
   end
   initial begin
      repeat (10000) @(posedge i_clk_sys);
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
